// >>> ascii_defs.svh
`ifndef ASCII_DEFS_SVH
`define ASCII_DEFS_SVH

// Character codes on the line
`define START_CHAR 8'h7e
`define SPACE_CHAR 8'h20
`define CR_CHAR 8'h0d
`define PRINT_LO 8'h21
`define PRINT_HI 8'h7e

// Status letters of a reply
`define OK_HI 8'h4f
`define OK_LO 8'h4b
`define FAULT_HI 8'h45
`define FAULT_LO 8'h52

// Reply framing
`define REPLY_LEN 4'hc
`define BUSY_CODE 8'h01

// Timing
`define CLK_PERIOD_NS 4
`define REPLY_DEADLINE_MS 500
`define REPLY_DEADLINE_CYC (`REPLY_DEADLINE_MS * 1000000 / `CLK_PERIOD_NS)
`define RX_TIMEOUT_CYC 25000000

`endif

// >>> pkt_pkg.sv
package pkt_pkg;

	typedef enum logic [3:0]
	{
		S_IDLE  = 4'h0,
		S_SP1   = 4'h1,
		S_AHI   = 4'h2,
		S_ALO   = 4'h3,
		S_SP2   = 4'h4,
		S_CHI   = 4'h5,
		S_CLO   = 4'h6,
		S_SP3   = 4'h7,
		S_BODY  = 4'h8,
		S_REPLY = 4'h9
	} rx_state_t;

	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
	endfunction

	function automatic logic [7:0] to_hex(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

endpackage

// >>> reply_if.sv
`timescale 1ns/1ns
interface reply_if;
	logic [7:0] addr;
	logic [7:0] code;
	logic       fault;
	logic [3:0] idx;
	logic [7:0] chr;

	modport main   (output addr, code, fault, idx, input chr);
	modport framer (input addr, code, fault, idx, output chr);
endinterface

// >>> reply_framer.sv
`timescale 1ns/1ns
`include "ascii_defs.svh"
module reply_framer
	import pkt_pkg::*;
(
	reply_if.framer rp
);
	logic [7:0] st_hi;
	logic [7:0] st_lo;
	logic [7:0] sum;

	// Character of the reply at position idx, checksum over bytes 0..8
	always_comb
	begin
		st_hi = rp.fault ? `FAULT_HI : `OK_HI;
		st_lo = rp.fault ? `FAULT_LO : `OK_LO;
		sum = to_hex(rp.addr[7:4]) + to_hex(rp.addr[3:0]) + st_hi + st_lo
			+ to_hex(rp.code[7:4]) + to_hex(rp.code[3:0])
			+ `SPACE_CHAR + `SPACE_CHAR + `SPACE_CHAR;
		unique case (rp.idx)
			4'h0: rp.chr = to_hex(rp.addr[7:4]);
			4'h1: rp.chr = to_hex(rp.addr[3:0]);
			4'h2: rp.chr = `SPACE_CHAR;
			4'h3: rp.chr = st_hi;
			4'h4: rp.chr = st_lo;
			4'h5: rp.chr = `SPACE_CHAR;
			4'h6: rp.chr = to_hex(rp.code[7:4]);
			4'h7: rp.chr = to_hex(rp.code[3:0]);
			4'h8: rp.chr = `SPACE_CHAR;
			4'h9: rp.chr = to_hex(sum[7:4]);
			4'ha: rp.chr = to_hex(sum[3:0]);
			default: rp.chr = `CR_CHAR;
		endcase
	end
endmodule

// >>> timeout_timer.sv
`timescale 1ns/1ns
module timeout_timer #(
	parameter int LOAD_CYC = 16
)(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic load,
	input  wire logic stop,
	output logic      expired,
	output logic      running
);
	logic [31:0] cnt_r;

	// Expiry is a one-cycle pulse, the timer then stands still
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_r <= 32'h0;
			running <= 1'b0;
			expired <= 1'b0;
		end
		else if (load)
		begin
			cnt_r <= 32'(LOAD_CYC - 1);
			running <= 1'b1;
			expired <= 1'b0;
		end
		else if (stop)
		begin
			running <= 1'b0;
			expired <= 1'b0;
		end
		else if (running && cnt_r == 32'h0)
		begin
			running <= 1'b0;
			expired <= 1'b1;
		end
		else
		begin
			if (running)
				cnt_r <= cnt_r - 32'h1;
			expired <= 1'b0;
		end
	end
endmodule

// >>> ascii_packet_responder.sv
`timescale 1ns/1ns
`include "ascii_defs.svh"
module ascii_packet_responder
	import pkt_pkg::*;
#(
	parameter int RX_TIMEOUT_CYC     = `RX_TIMEOUT_CYC,
	parameter int REPLY_DEADLINE_CYC = `REPLY_DEADLINE_CYC
)(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_valid,
	input  wire logic [7:0] unit_addr,
	input  wire logic       exec_busy,
	input  wire logic       cmd_reject,
	input  wire logic [7:0] reject_code,
	input  wire logic [7:0] accept_code,
	input  wire logic       tx_ready,
	output logic      [7:0] tx_data,
	output logic            tx_valid,
	output logic            exec_valid,
	output logic      [7:0] exec_cmd,
	output logic            collecting
);
	rx_state_t  st_r;
	rx_state_t  st_nxt;
	logic [3:0] ahi_r;
	logic [7:0] cmd_hold_r;
	logic [7:0] sum_r;
	logic [7:0] s1_r;
	logic [7:0] s2_r;
	logic [7:0] c1_r;
	logic [7:0] c2_r;
	logic [1:0] tok_len_r;
	logic       fault_r;
	logic [7:0] code_r;
	logic       pend_r;
	logic [3:0] idx_r;
	logic [7:0] tx_data_r;
	logic       tx_valid_r;
	logic       exec_valid_r;
	logic [7:0] exec_cmd_r;
	logic       collecting_r;
	logic       is_start;
	logic       is_sp;
	logic       is_cr;
	logic       is_print;
	logic       in_collect;
	logic       sum_ok;
	logic       accept;
	logic       send_done;
	logic       tmr_load;
	logic       tmr_stop;
	logic       tmr_expired;
	logic       tmr_running;

	reply_if rp();

	assign tx_data    = tx_data_r;
	assign tx_valid   = tx_valid_r;
	assign exec_valid = exec_valid_r;
	assign exec_cmd   = exec_cmd_r;
	assign collecting = collecting_r;

	assign rp.addr  = unit_addr;
	assign rp.fault = fault_r;
	assign rp.code  = code_r;
	assign rp.idx   = idx_r;

	reply_framer u_framer
	(
		.rp (rp)
	);

	timeout_timer #(
		.LOAD_CYC (RX_TIMEOUT_CYC)
	) u_timer (
		.clk     (clk),
		.srst    (srst),
		.load    (tmr_load),
		.stop    (tmr_stop),
		.expired (tmr_expired),
		.running (tmr_running)
	);

	always_comb
	begin
		is_start = rx_valid && rx_data == `START_CHAR;
		is_sp = rx_valid && rx_data == `SPACE_CHAR;
		is_cr = rx_valid && rx_data == `CR_CHAR;
		is_print = rx_data >= `PRINT_LO && rx_data <= `PRINT_HI;
		in_collect = st_r != S_IDLE && st_r != S_REPLY;
		// Last token must be exactly two hex digits after a space
		sum_ok = tok_len_r == 2'h2 && is_hex(c2_r) && is_hex(c1_r)
			&& {hex_val(c2_r), hex_val(c1_r)} == s2_r;
		// Expiry in the terminator's cycle wins, as the state does
		accept = st_r == S_BODY && is_cr && sum_ok
			&& !tmr_expired;
		send_done = st_r == S_REPLY && idx_r == `REPLY_LEN
			&& (!tx_valid_r || tx_ready);
		tmr_load = is_start && st_r != S_REPLY;
		tmr_stop = in_collect && !is_start
			&& (st_nxt == S_IDLE || st_nxt == S_REPLY);
	end

	// Packet collection and reply sequencing
	always_comb
	begin
		st_nxt = st_r;
		if (st_r == S_REPLY)
		begin
			if (send_done)
				st_nxt = S_IDLE;
		end
		else if (is_start)
			st_nxt = S_SP1;
		else if (in_collect && tmr_expired)
			st_nxt = S_IDLE;
		else if (rx_valid && in_collect)
		begin
			unique case (st_r)
				S_SP1: st_nxt = is_sp ? S_AHI : S_IDLE;
				S_AHI: st_nxt = is_hex(rx_data) ? S_ALO : S_IDLE;
				S_ALO: st_nxt = (is_hex(rx_data)
					&& {ahi_r, hex_val(rx_data)} == unit_addr)
					? S_SP2 : S_IDLE;
				S_SP2: st_nxt = is_sp ? S_CHI : S_IDLE;
				S_CHI: st_nxt = is_hex(rx_data) ? S_CLO : S_IDLE;
				S_CLO: st_nxt = is_hex(rx_data) ? S_SP3 : S_IDLE;
				S_SP3: st_nxt = is_sp ? S_BODY : S_IDLE;
				S_BODY:
				begin
					if (is_cr)
						st_nxt = sum_ok ? S_REPLY : S_IDLE;
					else if (!is_sp && !is_print)
						st_nxt = S_IDLE;
				end
				default: st_nxt = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_r <= S_IDLE;
			collecting_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			collecting_r <= st_nxt != S_IDLE && st_nxt != S_REPLY;
		end
	end

	// Running sums lag the stream so the checksum bytes drop out
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sum_r <= 8'h00;
			s1_r <= 8'h00;
			s2_r <= 8'h00;
			c1_r <= 8'h00;
			c2_r <= 8'h00;
			tok_len_r <= 2'h0;
			ahi_r <= 4'h0;
			cmd_hold_r <= 8'h00;
		end
		else if (tmr_load)
		begin
			sum_r <= 8'h00;
			s1_r <= 8'h00;
			s2_r <= 8'h00;
			tok_len_r <= 2'h0;
		end
		else if (rx_valid && in_collect)
		begin
			sum_r <= sum_r + rx_data;
			s1_r <= sum_r;
			s2_r <= s1_r;
			c1_r <= rx_data;
			c2_r <= c1_r;
			if (is_sp)
				tok_len_r <= 2'h0;
			else if (tok_len_r != 2'h3)
				tok_len_r <= tok_len_r + 2'h1;
			if (st_r == S_AHI)
				ahi_r <= hex_val(rx_data);
			if (st_r == S_CHI)
				cmd_hold_r[7:4] <= hex_val(rx_data);
			if (st_r == S_CLO)
				cmd_hold_r[3:0] <= hex_val(rx_data);
		end
	end

	// Reply status and code chosen when the packet is accepted
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fault_r <= 1'b0;
			code_r <= 8'h00;
			pend_r <= 1'b0;
		end
		else if (accept)
		begin
			fault_r <= exec_busy || cmd_reject;
			pend_r <= !(exec_busy || cmd_reject);
			if (exec_busy)
				code_r <= `BUSY_CODE;
			else if (cmd_reject)
				code_r <= reject_code;
			else
				code_r <= accept_code;
		end
		else if (send_done)
			pend_r <= 1'b0;
	end

	// Command handed to execution only once the reply is out
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			exec_valid_r <= 1'b0;
			exec_cmd_r <= 8'h00;
		end
		else
		begin
			exec_valid_r <= send_done && pend_r;
			if (send_done && pend_r)
				exec_cmd_r <= cmd_hold_r;
		end
	end

	// Reply bytes, address first, no start character
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			idx_r <= 4'h0;
			tx_data_r <= 8'h00;
			tx_valid_r <= 1'b0;
		end
		else if (st_r == S_REPLY && (!tx_valid_r || tx_ready))
		begin
			if (idx_r == `REPLY_LEN)
				tx_valid_r <= 1'b0;
			else
			begin
				tx_data_r <= rp.chr;
				tx_valid_r <= 1'b1;
				idx_r <= idx_r + 4'h1;
			end
		end
		else if (st_r != S_REPLY)
			idx_r <= 4'h0;
	end

	// Checking helpers
	logic [31:0] dl_cnt_r;
	logic [3:0]  beats_r;

	always_ff @(posedge clk)
	begin
		if (srst)
			dl_cnt_r <= 32'h0;
		else if (accept)
			dl_cnt_r <= 32'h1;
		else if (tx_valid_r)
			dl_cnt_r <= 32'h0;
		else if (dl_cnt_r != 32'h0)
			dl_cnt_r <= dl_cnt_r + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (srst || accept)
			beats_r <= 4'h0;
		else if (st_r == S_REPLY && tx_valid_r && tx_ready)
			beats_r <= beats_r + 4'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_start_collect: assert property (
		st_r == S_IDLE && is_start |=> st_r == S_SP1 && tmr_running)
		else $error("start char did not open collection");
	a_timeout_drop: assert property (
		in_collect && tmr_expired && !is_start |=> st_r == S_IDLE)
		else $error("timeout did not drop packet");
	a_restart_fresh: assert property (
		in_collect && is_start
		|=> st_r == S_SP1 && sum_r == 8'h00 && tmr_running)
		else $error("restart did not clear collection");
	a_bad_sum_drop: assert property (
		st_r == S_BODY && is_cr && !sum_ok
		|=> st_r == S_IDLE && !tmr_running ##1 !tx_valid_r)
		else $error("bad checksum not dropped silently");
	a_hex_reject: assert property (
		(st_r == S_AHI || st_r == S_CHI) && rx_valid && !is_start
		&& !is_hex(rx_data) |=> st_r == S_IDLE)
		else $error("non-hex character accepted");
	a_addr_mismatch: assert property (
		st_r == S_ALO && rx_valid && is_hex(rx_data) && !is_start
		&& {ahi_r, hex_val(rx_data)} != unit_addr |=> st_r == S_IDLE)
		else $error("foreign address accepted");
	a_reply_entry: assert property (
		$rose(st_r == S_REPLY) |-> $past(accept))
		else $error("reply without checked packet");
	a_reply_deadline: assert property (
		dl_cnt_r < 32'(REPLY_DEADLINE_CYC))
		else $error("reply start late");
	a_first_addr: assert property (
		$rose(st_r == S_REPLY)
		|=> tx_valid_r && tx_data_r == to_hex(unit_addr[7:4]))
		else $error("reply does not open with address");
	a_busy_fault: assert property (
		accept && exec_busy |=> fault_r && code_r == `BUSY_CODE)
		else $error("busy unit did not fault");
	a_reply_length: assert property (
		send_done |-> beats_r == `REPLY_LEN - 4'h1)
		else $error("reply length wrong");
	a_exec_after: assert property (
		exec_valid_r |-> st_r == S_IDLE && $past(st_r) == S_REPLY)
		else $error("execution not after reply");

	c_ok_reply: cover property (
		accept && !exec_busy && !cmd_reject ##[1:60] exec_valid_r);
	c_busy_reply: cover property (accept && exec_busy);
	c_timeout: cover property (in_collect && tmr_expired);
	c_restart: cover property (in_collect && is_start);
endmodule

// >>> host_model.sv
`timescale 1ns/1ns
module host_model (
	input  wire logic       clk,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic       slow;

	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end

	// Idle line toggles each cycle between the inverted last character and the last character
	always @(negedge clk)
	begin
		if (txq.size() > 0)
		begin
			rx_data <= txq.pop_front();
			rx_valid <= 1'b1;
		end
		else
		begin
			rx_data <= ~rx_data;
			rx_valid <= 1'b0;
		end
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
			rxq.push_back(tx_data);
	end

	task automatic send(input logic [7:0] b[$]);
		foreach (b[i])
			txq.push_back(b[i]);
		// One character leaves per cycle, so the wait has a fixed bound
		repeat (b.size() + 1) @(posedge clk);
	endtask
endmodule

// >>> ascii_packet_responder_tb.sv
`timescale 1ns/1ns
module ascii_packet_responder_tb;
	logic       clk;
	logic       srst;
	logic [7:0] rx_data;
	logic       rx_valid;
	logic [7:0] unit_addr;
	logic       exec_busy;
	logic       cmd_reject;
	logic [7:0] reject_code;
	logic [7:0] accept_code;
	logic       tx_ready;
	logic [7:0] tx_data;
	logic       tx_valid;
	logic       exec_valid;
	logic [7:0] exec_cmd;
	logic       collecting;
	int         fails;
	int         cmp_count;
	int         exec_cnt;
	logic [7:0] last_cmd;
	logic [7:0] pkt[$];

	host_model host_model_i (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	ascii_packet_responder #(.RX_TIMEOUT_CYC(50), .REPLY_DEADLINE_CYC(1000))
		ascii_packet_responder_i (.clk(clk), .srst(srst), .rx_data(rx_data),
		.rx_valid(rx_valid), .unit_addr(unit_addr), .exec_busy(exec_busy),
		.cmd_reject(cmd_reject), .reject_code(reject_code),
		.accept_code(accept_code), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
		.collecting(collecting));

	always #2 clk = ~clk;

	always @(posedge clk)
	begin
		if (exec_valid === 1'b1)
		begin
			exec_cnt++;
			last_cmd = exec_cmd;
		end
	end

	task automatic conclude();
		$display("fails=%0d comparisons=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t %s got %b", $time, msg, got);
		end
	endtask

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction

	// Mode: 0 good, 1 checksum off, 2 foreign address, 3 lower-case hex,
	// 4 space before terminator, 5 no space after start
	function automatic void build(input logic [7:0] a, c, input int m);
		logic [7:0] b[$];
		logic [7:0] ck;
		b = {8'h20, hx(a[7:4]), hx(a[3:0]), 8'h20, hx(c[7:4]), hx(c[3:0]),
			8'h20};
		if (m == 2)
			b[1] = hx(~a[7:4]);
		if (m == 3)
			b[4] = b[4] | 8'h20;
		if (m == 5)
			b[0] = 8'h41;
		ck = 8'h00;
		foreach (b[i])
			ck += b[i];
		if (m == 1)
			ck += 8'h01;
		pkt = {8'h7e, b, hx(ck[7:4]), hx(ck[3:0])};
		if (m == 4)
			pkt.push_back(8'h20);
		pkt.push_back(8'h0d);
	endfunction

	task automatic setup(input logic [7:0] a, input logic busy, rej, slow);
		repeat (20) @(posedge clk);
		@(negedge clk);
		host_model_i.rxq.delete();
		unit_addr = a;
		exec_busy = busy;
		cmd_reject = rej;
		host_model_i.slow = slow;
	endtask

	task automatic expect_reply(input logic [7:0] a, s1, s2, code);
		logic [7:0] e[12];
		logic [7:0] ck;
		int         k;
		e = '{hx(a[7:4]), hx(a[3:0]), 8'h20, s1, s2, 8'h20, hx(code[7:4]),
			hx(code[3:0]), 8'h20, 8'h00, 8'h00, 8'h0d};
		ck = 8'h00;
		for (k = 0; k < 9; k++)
			ck += e[k];
		e[9] = hx(ck[7:4]);
		e[10] = hx(ck[3:0]);
		k = 0;
		while (host_model_i.rxq.size() < 12 && k < 400)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 400)
		begin
			fails++;
			$display("CHECK FAILED t=%0t no reply", $time);
			conclude();
		end
		repeat (4) @(posedge clk);
		chk_byte(8'(host_model_i.rxq.size()), 8'h0c, "length");
		foreach (e[j])
			chk_byte(host_model_i.rxq[j], e[j], "reply");
		chk_flag(collecting, 1'b0, "idle after reply");
	endtask

	task automatic t_accept(input logic [7:0] a, c, code, input logic slow);
		int n;
		setup(a, 1'b0, 1'b0, slow);
		accept_code = code;
		n = exec_cnt;
		build(a, c, 0);
		host_model_i.send(pkt);
		expect_reply(a, 8'h4f, 8'h4b, code);
		chk_byte(8'(exec_cnt - n), 8'h01, "exec count");
		chk_byte(last_cmd, c, "exec cmd");
	endtask

	task automatic t_error(input logic busy, input logic [7:0] rc, exp);
		int n;
		setup(8'h21, busy, 1'b1, 1'b0);
		reject_code = rc;
		n = exec_cnt;
		build(8'h21, 8'h44, 0);
		host_model_i.send(pkt);
		expect_reply(8'h21, 8'h45, 8'h52, exp);
		chk_byte(8'(exec_cnt - n), 8'h00, "no exec");
	endtask

	task automatic t_drops();
		int n;
		for (int m = 1; m <= 5; m++)
		begin
			setup(8'h5c, 1'b0, 1'b0, 1'b0);
			n = exec_cnt;
			build(8'h5c, 8'hcd, m);
			host_model_i.send(pkt);
			repeat (30) @(posedge clk);
			chk_byte(8'(host_model_i.rxq.size()), 8'h00, "drop");
			chk_flag(collecting, 1'b0, "drop idle");
			chk_byte(8'(exec_cnt - n), 8'h00, "drop exec");
		end
	endtask

	task automatic t_timeout();
		setup(8'h5c, 1'b0, 1'b0, 1'b0);
		pkt = {8'h7e, 8'h20, 8'h35};
		host_model_i.send(pkt);
		chk_flag(collecting, 1'b1, "collect");
		repeat (45) @(posedge clk);
		@(negedge clk);
		chk_flag(collecting, 1'b1, "before expiry");
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk_flag(collecting, 1'b0, "expired");
		chk_byte(8'(host_model_i.rxq.size()), 8'h00, "no reply");
	endtask

	task automatic t_restart();
		setup(8'h5c, 1'b0, 1'b0, 1'b0);
		accept_code = 8'ha6;
		pkt = {8'h7e, 8'h20};
		host_model_i.send(pkt);
		repeat (40) @(posedge clk);
		build(8'h5c, 8'h0f, 0);
		host_model_i.send(pkt);
		expect_reply(8'h5c, 8'h4f, 8'h4b, 8'ha6);
	endtask

	initial
	begin
		clk = 1'b0;
		srst = 1'b1;
		unit_addr = 8'h00;
		exec_busy = 1'b0;
		cmd_reject = 1'b0;
		reject_code = 8'h00;
		accept_code = 8'h00;
		fails = 0;
		cmp_count = 0;
		exec_cnt = 0;
		host_model_i.slow = 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		chk_flag(tx_valid, 1'b0, "reset tx");
		chk_flag(collecting, 1'b0, "reset collect");
		t_accept(8'hff, 8'hc3, 8'h5a, 1'b0);
		t_accept(8'hff, 8'h5f, 8'h3c, 1'b0);
		t_accept(8'h00, 8'h00, 8'hff, 1'b1);
		t_error(1'b1, 8'h33, 8'h01);
		t_error(1'b0, 8'h7f, 8'h7f);
		t_drops();
		t_timeout();
		t_restart();
		conclude();
	end
endmodule
